/* rtl/cmrt_cfg.svh */
// constants for the compare/move/reverse/test execution slice
`ifndef CMRT_CFG_SVH
`define CMRT_CFG_SVH
`define CMRT_W 32
`define CMRT_HALF 16
`define CMRT_SIGN 31
`define CMRT_TOP_LSB 16
`define CMRT_BYTE 8
`define CMRT_ZERO32 32'h0000_0000
`define CMRT_ZERO8 8'h00
`define CMRT_ONE8 8'h01
`define CMRT_SH32 8'h20
`define CMRT_PC_MASK 32'hffff_fffe
`define CMRT_FLAGS_RST 4'h0
`endif

/* rtl/cmrt_pkg.sv */
// types of the compare/move/reverse/test execution slice
package cmrt_pkg;
  typedef enum logic [3:0] {
    CMRT_COMPARE_SUBTRACT,
    CMRT_COMPARE_ADD,
    CMRT_MOVE_VALUE,
    CMRT_MOVE_INVERTED,
    CMRT_MOVE_WIDE_IMMEDIATE,
    CMRT_MOVE_TOP_HALFWORD,
    CMRT_WORD_BYTE_REVERSE,
    CMRT_HALFWORD_BYTE_REVERSE,
    CMRT_SIGNED_HALFWORD_REVERSE,
    CMRT_BIT_ORDER_REVERSE,
    CMRT_BIT_TEST,
    CMRT_EQUIVALENCE_TEST
  } cmrt_op_t;

  typedef enum logic [2:0] {
    CMRT_SH_NONE,
    CMRT_SH_LOGICAL_LEFT_SHIFT,
    CMRT_SH_LOGICAL_RIGHT_SHIFT,
    CMRT_SH_ARITHMETIC_RIGHT_SHIFT,
    CMRT_SH_ROTATE_RIGHT,
    CMRT_SH_ROTATE_RIGHT_EXTEND
  } cmrt_shift_t;

  // flexible second operand: immediate or register with optional shift
  typedef struct packed {
    logic use_imm;
    logic [31:0] imm_value;
    logic imm_carry_valid;
    logic imm_carry;
    logic [31:0] shift_source_register;
    cmrt_shift_t shift_kind;
    logic [7:0] shift_amount;
  } cmrt_operand_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } cmrt_flags_t;

  typedef struct packed {
    logic valid;
    cmrt_op_t op;
    logic set_flags;
    logic [3:0] dest;
    logic [31:0] first_operand_register;
    logic [31:0] dest_old;
    logic [15:0] sixteen_bit_immediate;
    cmrt_operand_t flexible_second_operand;
  } cmrt_issue_t;
endpackage

/* rtl/cmrt_shifter.sv */
// flexible second operand shifter with carry out
`timescale 1ns/100ps
`include "cmrt_cfg.svh"
module cmrt_shifter
  import cmrt_pkg::*;
(
  input wire cmrt_operand_t i_operand,
  input wire logic i_carry_in,
  output logic [31:0] o_value,
  output logic o_carry,
  output logic o_carry_touched
);
  logic [31:0] src;
  logic [7:0] amt;
  logic [63:0] wide;
  logic [4:0] rot;

  always_comb begin
    src = i_operand.shift_source_register;
    amt = i_operand.shift_amount;
    wide = {`CMRT_ZERO32, src};
    rot = amt[4:0];
    o_value = src;
    o_carry = i_carry_in;
    o_carry_touched = 1'b0;
    if (i_operand.use_imm) begin
      o_value = i_operand.imm_value;
      // unrotated immediates keep the old carry
      o_carry = i_operand.imm_carry_valid ? i_operand.imm_carry : i_carry_in;
      o_carry_touched = i_operand.imm_carry_valid;
    end else if (amt != `CMRT_ZERO8 || i_operand.shift_kind == CMRT_SH_ROTATE_RIGHT_EXTEND) begin
      // zero length shifts leave carry as it was
      o_carry_touched = 1'b1;
      unique case (i_operand.shift_kind)
        CMRT_SH_NONE: begin
          o_carry_touched = 1'b0;
        end
        CMRT_SH_LOGICAL_LEFT_SHIFT: begin
          wide = (amt > `CMRT_SH32) ? 64'h0 : ({`CMRT_ZERO32, src} << amt);
          o_value = wide[31:0];
          o_carry = wide[32];
        end
        CMRT_SH_LOGICAL_RIGHT_SHIFT: begin
          wide = (amt > `CMRT_SH32) ? 64'h0 : ({src, `CMRT_ZERO32} >> amt);
          o_value = wide[63:32];
          o_carry = wide[31];
        end
        CMRT_SH_ARITHMETIC_RIGHT_SHIFT: begin
          wide = (amt >= `CMRT_SH32) ? {64{src[`CMRT_SIGN]}} :
                 64'($signed({src, `CMRT_ZERO32}) >>> amt);
          o_value = wide[63:32];
          o_carry = wide[31];
        end
        CMRT_SH_ROTATE_RIGHT: begin
          o_value = (src >> rot) | (src << (6'd32 - {1'b0, rot}));
          o_carry = o_value[`CMRT_SIGN];
        end
        CMRT_SH_ROTATE_RIGHT_EXTEND: begin
          o_value = {i_carry_in, src[31:1]};
          o_carry = src[0];
        end
        default: begin
          o_carry_touched = 1'b0;
        end
      endcase
    end
  end
endmodule // cmrt_shifter

/* rtl/cmrt_alu.sv */
// compare, move, reverse and test execution slice with flag register
// Operation
// - compare subtracts operand from register, sets flags, writes nothing
// - compare-negative adds operand to register, sets flags, writes nothing
// - both compares always update all four flags
// - move writes operand; inverted move writes its complement
// - inverted move complements every bit of the operand
// - wide immediate move loads sixteen bit value zero extended
// - move with register-count shift equals the shift operation
// - flagged moves set n,z, maybe carry, keep overflow
// - move to program counter branches to result with bit 0 cleared; written value keeps bit 0
// - move top writes upper halfword, keeps lower halfword
// - move top keeps flags; not aimed at stack pointer or program counter
// - word reverse swaps all four bytes
// - halfword reverse swaps bytes inside each halfword
// - signed halfword reverse swaps low bytes and sign extends
// - bit reverse mirrors bit i to bit 31 minus i
// - reversals keep all flags
// - bit test flag_setting_and operands, sets flags like flagged and
// - equivalence test xors operands, sets flags like flagged xor
// - test ops set n,z from result, keep overflow
// - shift carry is last bit out; zero length keeps carry
`timescale 1ns/100ps
`include "cmrt_cfg.svh"
module cmrt_alu
  import cmrt_pkg::*;
#(
  parameter int unsigned PC_INDEX = 15,
  parameter int unsigned SP_INDEX = 13
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire cmrt_issue_t i_issue,
  output logic o_wr_en,
  output logic [3:0] o_wr_dest,
  output logic [31:0] o_wr_data,
  output logic o_branch,
  output logic [31:0] o_branch_target,
  output cmrt_flags_t o_flags,
  output logic o_issue_fault
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] byte_swap32(input logic [31:0] v);
    byte_swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  function automatic logic [15:0] byte_swap16(input logic [15:0] v);
    byte_swap16 = {v[7:0], v[15:8]};
  endfunction

  function automatic logic [31:0] bit_mirror(input logic [31:0] v);
    logic [31:0] r;
    r = `CMRT_ZERO32;
    for (int i = 0; i < `CMRT_W; i++) begin
      r[`CMRT_SIGN - i] = v[i];
    end
    bit_mirror = r;
  endfunction

  function automatic logic is_compare(input cmrt_op_t op);
    is_compare = (op == CMRT_COMPARE_SUBTRACT) || (op == CMRT_COMPARE_ADD);
  endfunction

  // ****************************************************************
  // second operand
  // ****************************************************************
  cmrt_flags_t flags_q;
  cmrt_flags_t flags_d;
  logic [31:0] op2;
  logic op2_carry;
  logic op2_carry_touched;

  cmrt_shifter u_shifter (
    .i_operand(i_issue.flexible_second_operand),
    .i_carry_in(flags_q.c),
    .o_value(op2),
    .o_carry(op2_carry),
    .o_carry_touched(op2_carry_touched)
  );

  // ****************************************************************
  // result and flags
  // ****************************************************************
  logic [32:0] sum;
  logic [32:0] diff;
  logic [31:0] result;
  logic write_d;
  logic flag_upd;
  logic is_special;

  always_comb begin
    sum = {1'b0, i_issue.first_operand_register} + {1'b0, op2};
    diff = {1'b0, i_issue.first_operand_register} + {1'b0, ~op2} + 33'h1;
    result = `CMRT_ZERO32;
    write_d = 1'b0;
    flags_d = flags_q;
    flag_upd = 1'b0;
    unique case (i_issue.op)
      CMRT_COMPARE_SUBTRACT: begin
        result = diff[31:0];
        flags_d.c = diff[32];
        flags_d.v = (i_issue.first_operand_register[`CMRT_SIGN] != op2[`CMRT_SIGN]) &&
                    (diff[`CMRT_SIGN] != i_issue.first_operand_register[`CMRT_SIGN]);
        flag_upd = 1'b1;
      end
      CMRT_COMPARE_ADD: begin
        result = sum[31:0];
        flags_d.c = sum[32];
        flags_d.v = (i_issue.first_operand_register[`CMRT_SIGN] == op2[`CMRT_SIGN]) &&
                    (sum[`CMRT_SIGN] != op2[`CMRT_SIGN]);
        flag_upd = 1'b1;
      end
      CMRT_MOVE_VALUE: begin
        result = op2;
        write_d = 1'b1;
        flag_upd = i_issue.set_flags;
      end
      CMRT_MOVE_INVERTED: begin
        result = ~op2;
        write_d = 1'b1;
        flag_upd = i_issue.set_flags;
      end
      CMRT_MOVE_WIDE_IMMEDIATE: begin
        result = {16'h0000, i_issue.sixteen_bit_immediate};
        write_d = 1'b1;
      end
      CMRT_MOVE_TOP_HALFWORD: begin
        result = {i_issue.sixteen_bit_immediate, i_issue.dest_old[`CMRT_TOP_LSB-1:0]};
        write_d = 1'b1;
      end
      CMRT_WORD_BYTE_REVERSE: begin
        result = byte_swap32(i_issue.first_operand_register);
        write_d = 1'b1;
      end
      CMRT_HALFWORD_BYTE_REVERSE: begin
        result = {byte_swap16(i_issue.first_operand_register[31:16]),
                  byte_swap16(i_issue.first_operand_register[15:0])};
        write_d = 1'b1;
      end
      CMRT_SIGNED_HALFWORD_REVERSE: begin
        result = {{`CMRT_HALF{i_issue.first_operand_register[`CMRT_BYTE-1]}},
                  byte_swap16(i_issue.first_operand_register[15:0])};
        write_d = 1'b1;
      end
      CMRT_BIT_ORDER_REVERSE: begin
        result = bit_mirror(i_issue.first_operand_register);
        write_d = 1'b1;
      end
      CMRT_BIT_TEST: begin
        result = i_issue.first_operand_register & op2;
        flag_upd = 1'b1;
      end
      CMRT_EQUIVALENCE_TEST: begin
        result = i_issue.first_operand_register ^ op2;
        flag_upd = 1'b1;
      end
      default: begin
        result = `CMRT_ZERO32;
      end
    endcase
    // logical kinds take carry from the shifter only, never overflow
    if (flag_upd) begin
      flags_d.n = result[`CMRT_SIGN];
      flags_d.z = (result == `CMRT_ZERO32);
      if (!is_compare(i_issue.op)) begin
        flags_d.c = op2_carry_touched ? op2_carry : flags_q.c;
        flags_d.v = flags_q.v;
      end
    end
    if (!i_issue.valid) begin
      flags_d = flags_q;
      write_d = 1'b0;
    end
  end

  // issue checks: flags a misuse but still executes, the core decides how to trap
  always_comb begin
    is_special = (i_issue.dest == 4'(PC_INDEX)) || (i_issue.dest == 4'(SP_INDEX));
    o_issue_fault = 1'b0;
    if (i_issue.valid) begin
      // tests write nothing but still must not name a special register
      if (is_special && !is_compare(i_issue.op) && (i_issue.op != CMRT_MOVE_VALUE || i_issue.set_flags ||
          i_issue.flexible_second_operand.use_imm ||
          i_issue.flexible_second_operand.shift_kind != CMRT_SH_NONE)) begin
        o_issue_fault = 1'b1;
      end
      if (is_compare(i_issue.op) && i_issue.dest == 4'(PC_INDEX)) begin
        o_issue_fault = 1'b1;
      end
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_q <= `CMRT_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wr_en <= 1'b0;
      o_wr_dest <= 4'h0;
      o_wr_data <= `CMRT_ZERO32;
      o_branch <= 1'b0;
      o_branch_target <= `CMRT_ZERO32;
    end else begin
      o_wr_en <= write_d;
      o_wr_dest <= i_issue.dest;
      o_wr_data <= result;
      o_branch <= write_d && i_issue.op == CMRT_MOVE_VALUE && i_issue.dest == 4'(PC_INDEX);
      o_branch_target <= result & `CMRT_PC_MASK;
    end
  end

  assign o_flags = flags_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence cmp_issued;
    i_issue.valid && (i_issue.op == CMRT_COMPARE_SUBTRACT || i_issue.op == CMRT_COMPARE_ADD);
  endsequence

  sequence no_write_next;
    ##1 !o_wr_en;
  endsequence

  // short name for the first operand in the checks below
  logic [31:0] chk_a;
  assign chk_a = i_issue.first_operand_register;

  compare_no_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    cmp_issued |-> no_write_next) else $error("compare wrote a register");

  cmp_borrow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_COMPARE_SUBTRACT) |=>
    (o_flags.c == ($past(chk_a) >= $past(op2))))
    else $error("compare carry wrong");

  cmp_zero_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_COMPARE_SUBTRACT) |=>
    (o_flags.z == ($past(i_issue.first_operand_register) == $past(op2))))
    else $error("compare zero flag wrong");

  cmn_carry_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_COMPARE_ADD) |=> (o_flags.c == $past(sum[32])))
    else $error("compare-add carry wrong");

  cmn_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_COMPARE_ADD) |=>
    (o_flags.z == ($past(chk_a + op2) == `CMRT_ZERO32)))
    else $error("compare-add zero flag wrong");

  cmp_pc_fault_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && is_compare(i_issue.op) && i_issue.dest == 4'(PC_INDEX)) |-> o_issue_fault)
    else $error("compare on program counter not flagged");

  mov_value_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_MOVE_VALUE) |=> (o_wr_en && o_wr_data == $past(op2)))
    else $error("move value wrong");

  mvn_value_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_MOVE_INVERTED) |=> (o_wr_en && o_wr_data == ~$past(op2)))
    else $error("inverted move value wrong");

  wide_imm_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_MOVE_WIDE_IMMEDIATE) |=>
    (o_wr_en && o_wr_data == {16'h0000, $past(i_issue.sixteen_bit_immediate)}))
    else $error("wide immediate move wrong");

  move_flags_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.set_flags && (i_issue.op == CMRT_MOVE_VALUE || i_issue.op == CMRT_MOVE_INVERTED))
    |=> ($stable(o_flags.v) && o_flags.n == o_wr_data[`CMRT_SIGN] && o_flags.z == (o_wr_data == `CMRT_ZERO32)))
    else $error("flagged move flags wrong");

  special_fault_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && is_special && i_issue.op == CMRT_MOVE_VALUE && i_issue.set_flags) |-> o_issue_fault)
    else $error("flagged move on special register not flagged");

  pc_target_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_branch |-> (o_branch_target[0] == 1'b0 && o_branch_target[31:1] == o_wr_data[31:1]))
    else $error("branch target bit 0 set");

  move_top_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_MOVE_TOP_HALFWORD) |=>
    (o_wr_data[15:0] == $past(i_issue.dest_old[15:0]) && $stable(o_flags)))
    else $error("move top damaged low half or flags");

  move_top_high_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_MOVE_TOP_HALFWORD) |=>
    (o_wr_en && o_wr_data[31:16] == $past(i_issue.sixteen_bit_immediate)))
    else $error("move top upper half wrong");

  word_rev_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_WORD_BYTE_REVERSE) |=>
    (o_wr_data == $past({chk_a[7:0], chk_a[15:8], chk_a[23:16], chk_a[31:24]})))
    else $error("word byte reverse wrong");

  half_rev_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_HALFWORD_BYTE_REVERSE) |=>
    (o_wr_data == $past({chk_a[23:16], chk_a[31:24], chk_a[7:0], chk_a[15:8]})))
    else $error("halfword byte reverse wrong");

  signed_rev_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_SIGNED_HALFWORD_REVERSE) |=>
    (o_wr_data == $past({{16{chk_a[7]}}, chk_a[7:0], chk_a[15:8]})))
    else $error("signed halfword reverse wrong");

  bit_rev_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_BIT_ORDER_REVERSE) |=>
    (o_wr_data[0] == $past(chk_a[31]) && o_wr_data[31] == $past(chk_a[0]) && o_wr_data[12] == $past(chk_a[19])))
    else $error("bit reverse wrong");

  reverse_flags_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && (i_issue.op == CMRT_WORD_BYTE_REVERSE || i_issue.op == CMRT_BIT_ORDER_REVERSE))
    |=> $stable(o_flags)) else $error("reverse changed flags");

  test_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_BIT_TEST) |=> (o_flags.z == ($past(chk_a & op2) == `CMRT_ZERO32)))
    else $error("bit test zero flag wrong");

  test_overflow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && (i_issue.op == CMRT_BIT_TEST || i_issue.op == CMRT_EQUIVALENCE_TEST))
    |=> ($stable(o_flags.v) && !o_wr_en)) else $error("test touched overflow or wrote");

  teq_sign_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_EQUIVALENCE_TEST) |=>
    (o_flags.n == ($past(i_issue.first_operand_register[31]) ^ $past(op2[31]))))
    else $error("equivalence sign flag wrong");

  lsl_carry_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_MOVE_VALUE && i_issue.set_flags &&
     !i_issue.flexible_second_operand.use_imm && i_issue.flexible_second_operand.shift_amount == `CMRT_ONE8 &&
     i_issue.flexible_second_operand.shift_kind == CMRT_SH_LOGICAL_LEFT_SHIFT) |=>
    (o_flags.c == $past(i_issue.flexible_second_operand.shift_source_register[`CMRT_SIGN])))
    else $error("shift carry is not the last bit out");

  plain_carry_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_issue.valid && i_issue.op == CMRT_MOVE_VALUE && i_issue.set_flags && !op2_carry_touched)
    |=> $stable(o_flags.c)) else $error("plain move changed carry");
endmodule // cmrt_alu

/* verif/cmrt_issue_model.sv */
// issue stage and register file model facing the execution slice
`timescale 1ns/100ps
module cmrt_issue_model
  import cmrt_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_dest,
  input wire logic [31:0] i_wr_data,
  output cmrt_issue_t o_issue
);
  logic [31:0] regs_q [16];
  initial begin
    o_issue = '0;
    for (int i = 0; i < 16; i++) regs_q[i] = 32'h1357_9bdf ^ (i * 32'h0101_0101);
  end
  always @(posedge i_core_clk) begin
    if (i_wr_en === 1'b1) regs_q[i_wr_dest] <= i_wr_data;
  end
  // no forwarding: old dest value may lag a write one cycle ahead
  task automatic send(input cmrt_op_t op, input logic sf, input logic [3:0] dest, input logic [31:0] a,
                      input cmrt_operand_t b, input logic [15:0] imm);
    @(posedge i_core_clk);
    o_issue <= '{1'b1, op, sf, dest, a, regs_q[dest], imm, b};
  endtask
  // idle slots show the complement of the previous slot with valid cleared
  task automatic idle(input int n);
    cmrt_issue_t t;
    repeat (n) begin
      @(posedge i_core_clk);
      t = ~o_issue;
      t.valid = 1'b0;
      o_issue <= t;
    end
  endtask
endmodule // cmrt_issue_model

/* verif/testbench.sv */
// self-checking bench for the compare/move/reverse/test slice
`timescale 1ns/100ps
module testbench;
  import cmrt_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  cmrt_issue_t i_issue;
  logic o_wr_en;
  logic [3:0] o_wr_dest;
  logic [31:0] o_wr_data;
  logic o_branch;
  logic [31:0] o_branch_target;
  cmrt_flags_t o_flags;
  logic o_issue_fault;
  int n_errors = 0;
  int total_checks = 0;
  int seed;
  logic e_wr = 1'b0;
  logic e_br = 1'b0;
  logic [3:0] e_dest;
  logic [31:0] e_data;
  cmrt_flags_t e_fl = '0;

  always #20 i_core_clk = ~i_core_clk;

  cmrt_alu dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_issue(i_issue), .o_wr_en(o_wr_en),
    .o_wr_dest(o_wr_dest), .o_wr_data(o_wr_data), .o_branch(o_branch), .o_branch_target(o_branch_target),
    .o_flags(o_flags), .o_issue_fault(o_issue_fault));
  cmrt_issue_model iss (.i_core_clk(i_core_clk), .i_wr_en(o_wr_en), .i_wr_dest(o_wr_dest),
    .i_wr_data(o_wr_data), .o_issue(i_issue));

  // ****************************************
  // reference model
  // ****************************************
  function automatic logic [32:0] shift_of(input cmrt_operand_t b, input logic c);
    logic [31:0] s;
    s = b.shift_source_register;
    if (b.use_imm) return {b.imm_carry_valid ? b.imm_carry : c, b.imm_value};
    if (b.shift_kind == CMRT_SH_ROTATE_RIGHT_EXTEND) return {s[0], c, s[31:1]};
    if (b.shift_kind == CMRT_SH_NONE) return {c, s};
    // one bit per step, carry is the last bit to leave
    repeat (b.shift_amount) begin
      case (b.shift_kind)
        CMRT_SH_LOGICAL_LEFT_SHIFT: {c, s} = {s, 1'b0};
        CMRT_SH_LOGICAL_RIGHT_SHIFT: {s, c} = {1'b0, s};
        CMRT_SH_ARITHMETIC_RIGHT_SHIFT: {s, c} = {s[31], s};
        default: {s, c} = {s[0], s};
      endcase
    end
    return {c, s};
  endfunction

  function automatic logic exp_fault(input cmrt_issue_t s);
    logic plain;
    plain = s.op == CMRT_MOVE_VALUE && !s.set_flags && !s.flexible_second_operand.use_imm
            && s.flexible_second_operand.shift_kind == CMRT_SH_NONE;
    if (!s.valid) return 1'b0;
    if (s.op inside {CMRT_COMPARE_SUBTRACT, CMRT_COMPARE_ADD}) return s.dest == 4'hf;
    return (s.dest == 4'hd || s.dest == 4'hf) && !plain;
  endfunction

  task automatic model(input cmrt_issue_t s);
    logic [32:0] sh;
    logic [32:0] sum;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] r;
    logic nz;
    sh = shift_of(s.flexible_second_operand, e_fl.c);
    a = s.first_operand_register;
    b = sh[31:0];
    sum = (s.op == CMRT_COMPARE_ADD) ? {1'h0, a} + {1'h0, b} : {1'h0, a} + {1'h0, ~b} + 33'h1;
    e_wr = 1'b1;
    nz = s.set_flags && (s.op inside {CMRT_MOVE_VALUE, CMRT_MOVE_INVERTED});
    case (s.op)
      CMRT_COMPARE_SUBTRACT, CMRT_COMPARE_ADD: begin
        r = sum[31:0];
        e_wr = 1'b0;
        e_fl = '{r[31], r == 32'h0, sum[32], (a[31] ^ r[31]) & (a[31] ^ b[31] ^ (s.op == CMRT_COMPARE_ADD))};
      end
      CMRT_MOVE_VALUE: r = b;
      CMRT_MOVE_INVERTED: r = ~b;
      CMRT_MOVE_WIDE_IMMEDIATE: r = {16'h0, s.sixteen_bit_immediate};
      CMRT_MOVE_TOP_HALFWORD: r = {s.sixteen_bit_immediate, s.dest_old[15:0]};
      CMRT_WORD_BYTE_REVERSE: r = {a[7:0], a[15:8], a[23:16], a[31:24]};
      CMRT_HALFWORD_BYTE_REVERSE: r = {a[23:16], a[31:24], a[7:0], a[15:8]};
      CMRT_SIGNED_HALFWORD_REVERSE: r = {{16{a[7]}}, a[7:0], a[15:8]};
      CMRT_BIT_ORDER_REVERSE: begin
        for (int i = 0; i < 32; i++) r[i] = a[31 - i];
      end
      CMRT_BIT_TEST, CMRT_EQUIVALENCE_TEST: begin
        r = (s.op == CMRT_BIT_TEST) ? (a & b) : (a ^ b);
        e_wr = 1'b0;
        nz = 1'b1;
      end
      default: r = 32'h0;
    endcase
    if (nz) e_fl = '{r[31], r == 32'h0, sh[32], e_fl.v};
    e_dest = s.dest;
    e_data = r;
    e_br = e_wr && s.op == CMRT_MOVE_VALUE && s.dest == 4'hf;
  endtask

  always @(posedge i_core_clk or negedge i_rst_n) begin
    e_wr = 1'b0;
    e_br = 1'b0;
    if (!i_rst_n) e_fl = '0;
    else if (i_issue.valid === 1'b1) model(i_issue);
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // registered results settle well before the falling edge
  always @(negedge i_core_clk) begin
    check(40'({o_wr_en, o_branch}), 40'({e_wr, e_br}), "write or branch pulse");
    check(40'(o_flags), 40'(e_fl), "flags");
    check(40'(o_issue_fault), 40'(exp_fault(i_issue)), "misuse flag");
    if (e_wr) check({o_wr_dest, o_wr_data}, {e_dest, e_data}, "write data");
    if (e_br) check(40'(o_branch_target), 40'({e_data[31:1], 1'h0}), "branch target");
  end

  // ****************************************
  // stimulus
  // ****************************************
  function automatic cmrt_operand_t opnd(input logic ui, input logic [31:0] v, input logic civ, input logic c,
                                         input cmrt_shift_t k, input logic [7:0] n);
    return '{ui, v, civ, c, v, k, n};
  endfunction

  task automatic go(input cmrt_op_t op, input logic sf, input logic [3:0] d, input logic [31:0] a,
                    input logic ui, input logic [31:0] v, input cmrt_shift_t k, input logic [7:0] n);
    iss.send(op, sf, d, a, opnd(ui, v, 1'b0, 1'b0, k, n), v[15:0]);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #(40 * 5000);
    n_errors++;
    print_verdict();
  end

  initial begin
    cmrt_op_t op;
    seed = $urandom(73013);
    repeat (5) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    go(CMRT_COMPARE_SUBTRACT, 1'b0, 4'h2, 32'h5, 1'b1, 32'h5, CMRT_SH_NONE, 8'h00);
    go(CMRT_COMPARE_SUBTRACT, 1'b0, 4'h2, 32'h8000_0000, 1'b1, 32'h1, CMRT_SH_NONE, 8'h00);
    go(CMRT_COMPARE_ADD, 1'b0, 4'h2, 32'hffff_ffff, 1'b1, 32'h1, CMRT_SH_NONE, 8'h00);
    go(CMRT_COMPARE_ADD, 1'b0, 4'h2, 32'h7fff_ffff, 1'b1, 32'h1, CMRT_SH_NONE, 8'h00);
    go(CMRT_MOVE_VALUE, 1'b0, 4'hf, 32'h0, 1'b0, 32'h1001, CMRT_SH_NONE, 8'h00);
    go(CMRT_MOVE_VALUE, 1'b0, 4'hd, 32'h0, 1'b0, 32'h2000_0400, CMRT_SH_NONE, 8'h00);
    go(CMRT_MOVE_WIDE_IMMEDIATE, 1'b0, 4'h3, 32'h0, 1'b1, 32'hffff, CMRT_SH_NONE, 8'h00);
    go(CMRT_MOVE_TOP_HALFWORD, 1'b0, 4'h3, 32'h0, 1'b1, 32'hf123, CMRT_SH_NONE, 8'h00);
    go(CMRT_MOVE_INVERTED, 1'b1, 4'h2, 32'h0, 1'b1, 32'hf, CMRT_SH_NONE, 8'h00);
    for (int j = 0; j < 5; j++)
      go(CMRT_MOVE_VALUE, 1'b1, 4'h4, 32'h0, 1'b0, 32'h8000_0001, CMRT_SH_LOGICAL_LEFT_SHIFT,
         j == 0 ? 8'h00 : j == 1 ? 8'h01 : j == 2 ? 8'h1f : j == 3 ? 8'h20 : 8'h21);
    // deliberate misuse: still executes, only flagged
    go(CMRT_COMPARE_SUBTRACT, 1'b0, 4'hf, 32'h1, 1'b1, 32'h2, CMRT_SH_NONE, 8'h00);
    go(CMRT_MOVE_TOP_HALFWORD, 1'b0, 4'hd, 32'h0, 1'b1, 32'h00aa, CMRT_SH_NONE, 8'h00);
    go(CMRT_MOVE_VALUE, 1'b1, 4'hf, 32'h0, 1'b0, 32'h0300, CMRT_SH_NONE, 8'h00);
    go(CMRT_WORD_BYTE_REVERSE, 1'b0, 4'hf, 32'h1234_5678, 1'b0, 32'h0, CMRT_SH_NONE, 8'h00);
    for (int k = 0; k < 400; k++) begin
      op = cmrt_op_t'($urandom_range(0, 11));
      iss.send(op, op == CMRT_MOVE_WIDE_IMMEDIATE ? 1'b0 : 1'($urandom), 4'($urandom_range(0, 12)), $urandom,
               opnd(1'($urandom), $urandom, 1'($urandom), 1'($urandom),
                    cmrt_shift_t'($urandom_range(0, 5)),
                    8'($urandom_range(0, 40))), 16'($urandom));
      if ($urandom_range(0, 3) == 0) iss.idle(1);
    end
    iss.idle(1);
    i_rst_n <= 1'b0;
    iss.idle(2);
    i_rst_n <= 1'b1;
    go(CMRT_BIT_TEST, 1'b0, 4'h1, 32'h8000_0000, 1'b1, 32'h8000_0000, CMRT_SH_NONE, 8'h00);
    iss.idle(3);
    print_verdict();
  end
endmodule // testbench
